// ---- bench/rtc_alarm_assertions.sv ----
/* Port checker of the dual alarm unit.
   Assumes it is bound into rtc_dual_alarm_unit. */
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_checker
    import rtc_alarm_pkg::*;
#(
    parameter int FT_HALF_CYCLES = FT_HALF
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire reg_access_t reg_access,
    input wire logic [7:0]  reg_rdata,
    input wire logic [4:0]  pointer_addr,
    input wire logic        alarm1_irq_enable,
    input wire logic        backup_alarm_enable,
    input wire logic        backup_mode,
    input wire logic        freq_test_enable,
    input wire logic        out_level,
    input wire logic        second_alarm_enable,
    input wire logic        alarm1_flag,
    input wire logic        alarm2_flag,
    input wire logic        shared_interrupt_pin_out,
    input wire logic        shared_interrupt_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Flag byte read strobe and interrupt level on the pin
    wire logic rd_flag = reg_access.read && reg_access.addr == FLAG_ADDR;
    wire logic irq_on  = shared_interrupt_pin_oe && !shared_interrupt_pin_out;

    irq_drive_a:
        assert property ($rose(alarm1_flag) && alarm1_irq_enable && !freq_test_enable
            && !backup_mode && !rd_flag |=> irq_on) else $error("alarm one left pin idle");
    pointer_block_a:
        assert property ($past(pointer_addr) == FLAG_ADDR |-> !$rose(alarm1_flag)
            && !$rose(alarm2_flag)) else $error("flag set while pointer on flags");
    read_old_a:
        assert property (rd_flag |=> reg_rdata[6] == $past(alarm1_flag)
            && reg_rdata[5] == $past(alarm2_flag)) else $error("flag read value wrong");
    read_clear_a:
        assert property (rd_flag |=> (!alarm1_flag || $rose(alarm1_flag))
            && (!alarm2_flag || $rose(alarm2_flag))) else $error("flag not cleared");
    quiet_two_a:
        assert property ($rose(alarm2_flag) && !alarm1_flag && !freq_test_enable && !rd_flag
            && $stable(out_level) |=> $stable(shared_interrupt_pin_oe)) else $error("pin moved");
    two_off_a:
        assert property (!second_alarm_enable |=> !$rose(alarm2_flag))
            else $error("alarm two flag while disabled");
    ctrl_write_a:
        assert property (reg_access.write && reg_access.addr == CTRL_ADDR |=>
            second_alarm_enable == $past(reg_access.wdata[1])) else $error("enable not stored");
    no_backup_a:
        assert property (backup_mode && !backup_alarm_enable && out_level && !freq_test_enable
            && !shared_interrupt_pin_oe |=> !shared_interrupt_pin_oe) else $error("backup irq");
    backup_hold_a:
        assert property (backup_mode && out_level && !freq_test_enable && irq_on |=> irq_on)
            else $error("backup irq released");
    cover property (irq_on && backup_mode);
    cover property ($rose(alarm2_flag));
    cover property (rd_flag && alarm1_flag);
endmodule : rtc_alarm_checker
bind rtc_dual_alarm_unit rtc_alarm_checker #(.FT_HALF_CYCLES(FT_HALF_CYCLES)) i_checker (.*);
`default_nettype wire

// ---- bench/rtc_dual_alarm_unit_bench.sv ----
/* Self-checking bench of the dual alarm unit.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module rtc_dual_alarm_unit_bench import rtc_alarm_pkg::*;;
    logic        clock = 0, osc_clock = 0, reset = 1, second_update = 0, pend = 0;
    logic        abe = 0, bkp = 0, ft = 0, halt = 0, ie = 1, lvl = 1, prev;
    logic        s2en, f1, f2, p_out, p_oe;
    clock_time_t now = '0;
    reg_access_t acc;
    logic [4:0]  ptr;
    logic [7:0]  rd, e, mem[5], exp_q[$];
    int          miscompares = 0, comparisons = 0, seed = 53, n;
    logic [6:0]  al[5] = '{7'h03, 7'h15, 7'h12, 7'h30, 7'h45};
    logic [4:0]  codes[7] = '{RPT_SECOND, RPT_MINUTE, RPT_HOUR, RPT_DAY, RPT_MONTH,
                              RPT_YEAR, 5'h15};
    wire logic   pin = p_oe ? p_out : 1'b1;

    rtc_dual_alarm_unit #(.FT_HALF_CYCLES(4)) i_rtc_dual_alarm_unit (.clock(clock),
        .reset(reset), .osc_clock(osc_clock), .second_update(second_update),
        .current_time(now), .reg_access(acc), .reg_rdata(rd), .pointer_addr(ptr),
        .alarm1_irq_enable(ie), .backup_alarm_enable(abe), .backup_mode(bkp),
        .freq_test_enable(ft), .out_level(lvl), .oscillator_halt_bit(halt),
        .second_alarm_enable(s2en), .alarm1_flag(f1), .alarm2_flag(f2),
        .shared_interrupt_pin_in(pin), .shared_interrupt_pin_out(p_out),
        .shared_interrupt_pin_oe(p_oe));
    rtc_host_model i_rtc_host_model (.clock(clock), .reg_access(acc), .pointer_addr(ptr));

    // Clocks, the oscillator offset in phase
    initial forever #5 clock = ~clock;
    initial begin
        #7;
        forever #15 osc_clock = ~osc_clock;
    end
    // Read data compared against the oldest note
    always @(posedge clock) pend <= acc.read;
    always @(negedge clock) if (pend) begin
        e = exp_q.pop_front();
        `CHK(rd, e)
    end

    task automatic step(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : step
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        i_rtc_host_model.access(1'b0, a, 8'h00);
    endtask : rd_chk
    task automatic prog(input logic [4:0] b, input logic [4:0] r);
        for (int i = 0; i < 5; i++) i_rtc_host_model.access(1'b1, b + 5'(i), {r[4 - i], al[i]});
    endtask : prog
    // One second update; field k off by one, k of 5 matches exactly
    task automatic tick(input int k);
        logic [6:0] f[5];
        for (int i = 0; i < 5; i++) f[i] = al[i] ^ 7'(i == k);
        @(posedge osc_clock);
        #1;
        now = {f[0][4:0], f[1][5:0], f[2][5:0], f[3], f[4]};
        second_update = 1'b1;
        @(posedge osc_clock);
        #1;
        second_update = 1'b0;
        step(8);
    endtask : tick
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        step(4);
        reset = 1'b0;
        // Reset control byte, alarm-two bytes as memory, unmapped byte
        rd_chk(CTRL_ADDR, 8'h00);
        `CHK(s2en, 1'b0)
        for (int i = 0; i < 5; i++) begin
            mem[i] = 8'($random(seed));
            i_rtc_host_model.access(1'b1, ALARM2_BASE + 5'(i), mem[i]);
        end
        for (int i = 0; i < 5; i++) rd_chk(ALARM2_BASE + 5'(i), mem[i]);
        rd_chk(5'h1F, 8'h00);
        // Every repeat code against each field in turn
        i_rtc_host_model.access(1'b1, CTRL_ADDR, 8'h02);
        `CHK(s2en, 1'b1)
        foreach (codes[c]) begin
            prog(ALARM1_BASE, codes[c]);
            prog(ALARM2_BASE, codes[c]);
            for (int k = 0; k < 6; k++) begin
                n = int'(k == 5 || c == 6 || codes[c][4 - k]);
                tick(k);
                `CHK(p_oe, n[0])
                `CHK(f1, n[0])
                `CHK(f2, n[0])
                rd_chk(FLAG_ADDR, {1'b0, n[0], n[0], 5'h00});
                rd_chk(FLAG_ADDR, 8'h00);
            end
        end
        // Pointer left on the flag byte after the seconds write
        prog(ALARM1_BASE, RPT_SECOND);
        tick(5);
        rd_chk(FLAG_ADDR, 8'h00);
        // Alarm one off, alarm two polled only, then alarm two disabled
        i_rtc_host_model.disable_alarm(ALARM1_BASE);
        prog(ALARM2_BASE, RPT_YEAR);
        tick(5);
        `CHK(p_oe, 1'b0)
        rd_chk(FLAG_ADDR, 8'h20);
        i_rtc_host_model.access(1'b1, CTRL_ADDR, 8'h00);
        tick(5);
        rd_chk(FLAG_ADDR, 8'h00);
        // Backup without and with the backup alarm enable
        prog(ALARM1_BASE, RPT_SECOND);
        i_rtc_host_model.access(1'b1, CTRL_ADDR, 8'h00);
        // Alarm one with its interrupt enable off keeps the pin idle
        ie = 1'b0;
        tick(5);
        `CHK(p_oe, 1'b0)
        rd_chk(FLAG_ADDR, 8'h40);
        ie = 1'b1;
        bkp = 1'b1;
        tick(5);
        `CHK(p_oe, 1'b0)
        rd_chk(FLAG_ADDR, 8'h40);
        abe = 1'b1;
        tick(5);
        rd_chk(FLAG_ADDR, 8'h40);
        step(2);
        `CHK(p_oe, 1'b1)
        bkp = 1'b0;
        rd_chk(FLAG_ADDR, 8'h00);
        step(2);
        `CHK(p_oe, 1'b0)
        // Test output toggle count: running, halted, then level bit low
        ft = 1'b1;
        for (int h = 0; h < 3; h++) begin
            halt = h == 1;
            lvl = h != 2;
            step(4);
            n = 0;
            repeat (240) begin
                prev = p_out;
                step(1);
                n += int'(p_out != prev);
            end
            `CHK(n >= 19 * int'(h == 0) && n <= 21 * int'(h == 0), 1'b1)
            `CHK(p_oe, h != 1)
        end
        complete_run();
    end
endmodule : rtc_dual_alarm_unit_bench
`default_nettype wire

// ---- bench/rtc_host_model.sv ----
/* Host model: register strobes and address pointer of the serial front end.
   Assumes the unit takes each strobe at the first clock edge. */
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model
    import rtc_alarm_pkg::*;
(
    input  wire logic       clock,
    output var reg_access_t reg_access,
    output var logic [4:0]  pointer_addr
);
    initial begin
        reg_access = '0;
        pointer_addr = 5'h00;
    end
    // One byte access, then lines scrambled and pointer stepped on
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_access = '{wr, !wr, a, d};
        @(posedge clock);
        #1;
        reg_access = '{1'b0, 1'b0, ~a, ~d};
        pointer_addr = a + 5'h01;
    endtask : access
    // Turning an alarm off clears all five of its bytes, repeat bits included
    task automatic disable_alarm(input logic [4:0] b);
        for (int i = 0; i < 5; i++) access(1'b1, b + 5'(i), 8'h00);
    endtask : disable_alarm
endmodule : rtc_host_model
`default_nettype wire

// ---- hw/rtc_alarm_pkg.sv ----
/*
 * Shared constants, field layouts and carrier types of the dual alarm unit.
 * Assumes a byte-wide register space with 5-bit addresses, seen from the host side.
 */
package rtc_alarm_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ALARM1_BASE = 5'h0A;
    localparam logic [4:0] ALARM2_BASE = 5'h14;
    localparam logic [4:0] FLAG_ADDR   = 5'h0F;
    localparam logic [4:0] CTRL_ADDR   = 5'h13;
    localparam int         ALARM_BYTES = 5;
    localparam int         ALARM_COUNT = 2;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_ALARM2_BIT = 1;
    localparam int         FLAG_AF1_BIT    = 6;
    localparam int         FLAG_AF2_BIT    = 5;
    localparam int         REPEAT_BIT      = 7;
    localparam logic [7:0] REG_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // Repeat codes, bit 4 from the month byte down to bit 0 from seconds
    // ------------------------------------------------------------------
    localparam logic [4:0] RPT_SECOND = 5'h1F;
    localparam logic [4:0] RPT_MINUTE = 5'h1E;
    localparam logic [4:0] RPT_HOUR   = 5'h1C;
    localparam logic [4:0] RPT_DAY    = 5'h18;
    localparam logic [4:0] RPT_MONTH  = 5'h10;
    localparam logic [4:0] RPT_YEAR   = 5'h00;

    // ------------------------------------------------------------------
    // Oscillator timing
    // ------------------------------------------------------------------
    localparam int OSC_HZ  = 32768;
    localparam int FT_HZ   = 512;
    localparam int FT_HALF = OSC_HZ / FT_HZ / 2;   // Oscillator cycles per half period

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] month;
        logic [5:0] date;
        logic [5:0] hour;
        logic [6:0] minute;
        logic [6:0] second;
    } clock_time_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage : rtc_alarm_pkg

// ---- hw/rtc_dual_alarm_unit.sv ----
/*
 * Dual alarm unit of a real-time clock: alarm setting storage, repeat-code
 * matching, alarm flags, shared interrupt / frequency test pin drive.
 * Assumes an SPI front end on clock that issues one-cycle register accesses
 * and reports its address pointer, and timekeeping counters on osc_clock that
 * pulse second_update after each update and hold current_time stable between.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Alarm one settings live at 0Ah-0Eh, alarm two settings at 14h-18h.
// - Five repeat bits select every second, minute, hour, day, month or year.
// - Undefined repeat codes behave as the every-second setting.
// - A match under the selected criteria sets that alarm's own flag.
// - With the alarm-one interrupt enable set, an alarm-one match asserts the pin.
// - Pointer resting on the flag address suppresses alarm flags and interrupt.
// - Reading the flag register releases the interrupt and clears alarm flag one.
// - The clearing read still returns the flag set; later reads show zero.
// - In backup, alarm one reaches the pin only with backup alarm enable set.
// - A backup interrupt holds until supply returns and flags are read.
// - Control bit D1 of 13h enables alarm two, same matching and flag behaviour as alarm one.
// - Reading the flag register clears the alarm-two flag.
// - Alarm two drives no pin; it only sets its polled flag.
// - Alarm-two enable resets to zero; its five bytes then are plain memory.
// - Test and level bits set with oscillator running toggle the pin at 512 Hz.
module rtc_dual_alarm_unit
    import rtc_alarm_pkg::*;
#(
    parameter int FT_HALF_CYCLES = FT_HALF
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        osc_clock,
    input  wire logic        second_update,
    input  wire clock_time_t current_time,
    input  wire reg_access_t reg_access,
    output logic [7:0]       reg_rdata,
    input  wire logic [4:0]  pointer_addr,
    input  wire logic        alarm1_irq_enable,
    input  wire logic        backup_alarm_enable,
    input  wire logic        backup_mode,
    input  wire logic        freq_test_enable,
    input  wire logic        out_level,
    input  wire logic        oscillator_halt_bit,
    output logic             second_alarm_enable,
    output logic             alarm1_flag,
    output logic             alarm2_flag,
    input  wire logic        shared_interrupt_pin_in,
    output logic             shared_interrupt_pin_out,
    output logic             shared_interrupt_pin_oe
);

    // ------------------------------------------------------------------
    // Oscillator domain: second event toggle and 512 Hz divider
    // ------------------------------------------------------------------
    // Both stay in the oscillator domain; only their levels leave it
    logic       second_toggle;
    logic       next_second_toggle;
    logic [5:0] ft_count;
    logic [5:0] next_ft_count;
    logic       ft_wave;
    logic       next_ft_wave;

    // Divide the oscillator down to the test frequency
    // Six counter bits hold half periods of up to 64 oscillator cycles
    always_comb begin
        next_second_toggle = second_toggle ^ second_update;
        next_ft_count      = ft_count + 6'h01;
        next_ft_wave       = ft_wave;
        if (ft_count == 6'(FT_HALF_CYCLES - 1)) begin
            next_ft_count = 6'h00;
            next_ft_wave  = ~ft_wave;
        end
    end

    // Oscillator state clears with the shared reset
    always_ff @(posedge osc_clock or posedge reset) begin
        if (reset) begin
            second_toggle <= 1'b0;
            ft_count      <= 6'h00;
            ft_wave       <= 1'b0;
        end else begin
            second_toggle <= next_second_toggle;
            ft_count      <= next_ft_count;
            ft_wave       <= next_ft_wave;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into clock: three stages, change taken once stages 2 and 3 agree
    // ------------------------------------------------------------------
    // Of the second event only the toggle crosses; the time word is read several
    // cycles after it and has held still since the update
    logic [2:0] sec_sync;
    logic [2:0] ft_sync;
    logic       sec_seen;
    logic       next_sec_seen;
    logic       ft_level;
    logic       next_ft_level;
    logic       second_event;

    // Edge of the agreed second toggle marks one timekeeping update
    always_comb begin
        next_sec_seen = sec_seen;
        next_ft_level = ft_level;
        second_event  = 1'b0;
        if (sec_sync[1] == sec_sync[2] && sec_sync[2] != sec_seen) begin
            next_sec_seen = sec_sync[2];
            second_event  = 1'b1;
        end
        if (ft_sync[1] == ft_sync[2]) begin
            next_ft_level = ft_sync[2];
        end
    end

    // Three-stage shift per crossing signal
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sec_sync <= 3'h0;
            ft_sync  <= 3'h0;
            sec_seen <= 1'b0;
            ft_level <= 1'b0;
        end else begin
            sec_sync <= {sec_sync[1:0], second_toggle};
            ft_sync  <= {ft_sync[1:0], ft_wave};
            sec_seen <= next_sec_seen;
            ft_level <= next_ft_level;
        end
    end

    // ------------------------------------------------------------------
    // Alarm setting storage and register access
    // ------------------------------------------------------------------
    // Alarm-two bytes keep their contents whatever the enable says,
    // so they serve as plain memory while alarm two is off
    logic [7:0] alarm_mem      [ALARM_COUNT][ALARM_BYTES];
    logic [7:0] next_alarm_mem [ALARM_COUNT][ALARM_BYTES];
    logic [7:0] ctrl_byte;
    logic [7:0] next_ctrl_byte;
    logic [7:0] next_reg_rdata;
    logic       flag_read;

    assign flag_read           = reg_access.read && reg_access.addr == FLAG_ADDR;
    assign second_alarm_enable = ctrl_byte[CTRL_ALARM2_BIT];

    // Address decode for writes and registered read data
    always_comb begin
        next_alarm_mem = alarm_mem;
        next_ctrl_byte = ctrl_byte;
        next_reg_rdata = 8'h00;
        for (int a = 0; a < ALARM_COUNT; a++) begin
            for (int b = 0; b < ALARM_BYTES; b++) begin
                if (reg_access.addr == (a == 0 ? ALARM1_BASE : ALARM2_BASE) + 5'(b)) begin
                    if (reg_access.write) begin
                        next_alarm_mem[a][b] = reg_access.wdata;
                    end
                    if (reg_access.read) begin
                        next_reg_rdata = alarm_mem[a][b];
                    end
                end
            end
        end
        if (reg_access.addr == CTRL_ADDR) begin
            if (reg_access.write) begin
                next_ctrl_byte = reg_access.wdata;
            end
            if (reg_access.read) begin
                next_reg_rdata = ctrl_byte;
            end
        end
        if (flag_read) begin
            next_reg_rdata = 8'h00;
            next_reg_rdata[FLAG_AF1_BIT] = alarm1_flag;
            next_reg_rdata[FLAG_AF2_BIT] = alarm2_flag;
        end
    end

    // Settings and control byte clear on reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int a = 0; a < ALARM_COUNT; a++) begin
                for (int b = 0; b < ALARM_BYTES; b++) begin
                    alarm_mem[a][b] <= REG_RESET;
                end
            end
            ctrl_byte <= REG_RESET;
            reg_rdata <= 8'h00;
        end else begin
            alarm_mem <= next_alarm_mem;
            ctrl_byte <= next_ctrl_byte;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Repeat-code matching
    // ------------------------------------------------------------------
    // Repeat bit of each byte sits in bit 7, month byte first;
    // every unlisted code falls to the every-second match
    function automatic logic alarm_match(input logic [7:0] set [ALARM_BYTES],
                                         input clock_time_t now);
        logic [4:0] rpt;
        logic       mo;
        logic       d;
        logic       h;
        logic       m;
        logic       s;
        for (int b = 0; b < ALARM_BYTES; b++) begin
            rpt[ALARM_BYTES - 1 - b] = set[b][REPEAT_BIT];
        end
        mo = set[0][4:0] == now.month;
        d  = set[1][5:0] == now.date;
        h  = set[2][5:0] == now.hour;
        m  = set[3][6:0] == now.minute;
        s  = set[4][6:0] == now.second;
        case (rpt)
            RPT_MINUTE: alarm_match = s;
            RPT_HOUR:   alarm_match = s & m;
            RPT_DAY:    alarm_match = s & m & h;
            RPT_MONTH:  alarm_match = s & m & h & d;
            RPT_YEAR:   alarm_match = s & m & h & d & mo;
            default:    alarm_match = 1'b1;
        endcase
    endfunction : alarm_match

    // ------------------------------------------------------------------
    // Alarm flags and latched interrupt
    // ------------------------------------------------------------------
    // A match landing on the clearing read keeps its flag, so no event
    // is lost; the read still reports the value before the edge
    logic hit1;
    logic hit2;
    logic irq_latched;
    logic next_irq_latched;
    logic next_alarm1_flag;
    logic next_alarm2_flag;

    // Compare once per update, never while the pointer rests on the flags
    always_comb begin
        hit1 = second_event && pointer_addr != FLAG_ADDR
               && alarm_match(alarm_mem[0], current_time);
        hit2 = second_event && pointer_addr != FLAG_ADDR
               && second_alarm_enable
               && alarm_match(alarm_mem[1], current_time);
        // Set wins over the clearing read
        next_alarm1_flag = hit1 | (alarm1_flag & ~flag_read);
        next_alarm2_flag = hit2 | (alarm2_flag & ~flag_read);
        next_irq_latched = irq_latched;
        // Backup holds the interrupt through flag reads
        if (flag_read && !backup_mode) begin
            next_irq_latched = 1'b0;
        end
        if (hit1 && alarm1_irq_enable
            && (!backup_mode || backup_alarm_enable)) begin
            next_irq_latched = 1'b1;
        end
    end

    // Flags and interrupt latch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            alarm1_flag <= 1'b0;
            alarm2_flag <= 1'b0;
            irq_latched <= 1'b0;
        end else begin
            alarm1_flag <= next_alarm1_flag;
            alarm2_flag <= next_alarm2_flag;
            irq_latched <= next_irq_latched;
        end
    end

    // ------------------------------------------------------------------
    // Shared pin drive, alarm two never reaches it
    // ------------------------------------------------------------------
    // Registered drive keeps the pin free of decode glitches
    pin_drive_t pin;
    pin_drive_t next_pin;

    // Test wave first, then active-low interrupt, then static output level
    always_comb begin
        if (freq_test_enable && out_level && !oscillator_halt_bit) begin
            next_pin = '{out: ft_level, oe: 1'b1};
        end else if (irq_latched) begin
            next_pin = '{out: 1'b0, oe: 1'b1};
        end else begin
            next_pin = '{out: 1'b0, oe: ~out_level};
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin <= '{out: 1'b0, oe: 1'b0};
        end else begin
            pin <= next_pin;
        end
    end

    assign shared_interrupt_pin_out = pin.out;
    assign shared_interrupt_pin_oe  = pin.oe;

endmodule : rtc_dual_alarm_unit

`default_nettype wire
